/* File: core/liw_pkg.sv */
// Constants for the bus-attached watchdog: register map, fields, bus codes
package liw_pkg;
   // Register offsets from the I/O base
   localparam logic [2:0] OFF_COUNT_NOW_BYTE0 = 3'h0;
   localparam logic [2:0] OFF_COUNT_NOW_BYTE1 = 3'h1;
   localparam logic [2:0] OFF_COUNT_NOW_BYTE2 = 3'h2;
   localparam logic [2:0] OFF_RELOAD_VALUE_BYTE0 = 3'h3;
   localparam logic [2:0] OFF_RELOAD_VALUE_BYTE1 = 3'h4;
   localparam logic [2:0] OFF_RELOAD_VALUE_BYTE2 = 3'h5;
   localparam logic [2:0] OFF_TIMEOUT_STATUS = 3'h6;
   localparam logic [2:0] OFF_WATCHDOG_CONTROL = 3'h7;
   localparam logic [15:0] REG_SPAN = 16'h0008;

   // Field positions
   localparam int FIRST_TIMEOUT_FLAG_BIT = 0;
   localparam int SECOND_TIMEOUT_FLAG_BIT = 2;
   localparam int BOARD_RESET_ENABLE_BIT = 0;
   localparam int COUNT_ENABLE_BIT = 1;

   // Reset values, and the last count before zero
   localparam logic [23:0] COUNT_RESET = 24'h000000;
   localparam logic [23:0] RELOAD_RESET = 24'h000000;
   localparam logic [23:0] COUNT_LAST = 24'h000001;

   // Time base
   localparam logic [31:0] TICK_HZ = 32'h00008000;

   // Snooped POST port
   localparam logic [15:0] POST_PORT = 16'h0080;

   // Bus nibbles
   localparam logic [3:0] LPC_START = 4'h0;
   localparam logic [2:0] LPC_IO_READ = 3'h0;
   localparam logic [2:0] LPC_IO_WRITE = 3'h1;
   localparam logic [3:0] LPC_SYNC_READY = 4'h0;
   localparam logic [3:0] LPC_TAR_DRIVE = 4'hf;
   localparam logic [1:0] ADDR_NIBBLES_LAST = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CYCTYPE = 3'b001,
      ST_ADDR = 3'b010,
      ST_WDATA = 3'b011,
      ST_HOST_TAR = 3'b100,
      ST_SYNC = 3'b101,
      ST_RDATA = 3'b110,
      ST_DEV_TAR = 3'b111
   } liw_state_type;
endpackage

/* File: core/liw_watchdog.sv */
// Watchdog timer with byte registers reached by I/O cycles on the LPC bus
// What this block does
// - Current count readable at offsets 0-2; writes there reload it
// - Reload value in bytes at offsets 3-5
// - First zero sets status bit 0, interrupt
// - Bit0 cleared by write-one or port 80h
// - Zero with bit 0 set sets bit 2
// - Bit 2 interrupts; board reset if enabled
// - Writing one clears bit 2; zero ignored
// - First flag alone also requests interrupt
// - Control bit 1 enables decrementing
// - Control bit 0 allows board reset
// - Decrement once per 32.768 kHz tick
// - Any current-value write reloads counter
// - Enabled port 80h writes reload counter
// - Inactive after reset until enabled
`timescale 1ns/1ps
module liw_watchdog
   import liw_pkg::*;
#(
   parameter int CLK_HZ = 200_000_000
) (
   input wire logic sys_clk, // System clock, 200 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic lpcFrameN, // Bus frame, active low
   input wire logic [3:0] lpcAdIn, // Address/data pins, sampled
   output logic [3:0] lpcAdOut, // Address/data pins, driven value
   output logic lpcAdOe, // High while driving the pins
   input wire logic [15:0] ioBase, // I/O base address of the registers
   input wire logic port80Enable, // Port 80h kick option
   output logic watchdogIrq, // Interrupt request level
   output logic boardReset // Board reset request level
);

   liw_state_type state;
   logic [1:0] nib;
   logic isWrite;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic regWr;
   logic [2:0] regOff;
   logic [7:0] regData;
   logic postKick;
   logic [31:0] phase;
   logic tick;
   logic [23:0] count;
   logic [23:0] reload;
   logic firstTimeoutFlag;
   logic secondTimeoutFlag;
   logic countEnable;
   logic boardResetEnable;
   logic [15:0] offset;
   logic hit;
   logic zeroEvent;
   logic countWrite;
   logic statusWrite;

   function automatic logic [7:0] readReg(input logic [2:0] off);
      logic [7:0] r;
      r = 8'h00;
      if (off == OFF_COUNT_NOW_BYTE0) begin
         r = count[7:0];
      end else if (off == OFF_COUNT_NOW_BYTE1) begin
         r = count[15:8];
      end else if (off == OFF_COUNT_NOW_BYTE2) begin
         r = count[23:16];
      end else if (off == OFF_RELOAD_VALUE_BYTE0) begin
         r = reload[7:0];
      end else if (off == OFF_RELOAD_VALUE_BYTE1) begin
         r = reload[15:8];
      end else if (off == OFF_RELOAD_VALUE_BYTE2) begin
         r = reload[23:16];
      end else if (off == OFF_TIMEOUT_STATUS) begin
         r[FIRST_TIMEOUT_FLAG_BIT] = firstTimeoutFlag;
         r[SECOND_TIMEOUT_FLAG_BIT] = secondTimeoutFlag;
      end else begin
         r[COUNT_ENABLE_BIT] = countEnable;
         r[BOARD_RESET_ENABLE_BIT] = boardResetEnable;
      end
      return r;
   endfunction

   assign offset = addr - ioBase;
   assign hit = offset < REG_SPAN;
   assign zeroEvent = tick && countEnable && (count <= COUNT_LAST);
   assign countWrite = regWr && (regOff <= OFF_COUNT_NOW_BYTE2);
   assign statusWrite = regWr && (regOff == OFF_TIMEOUT_STATUS);

   // Bus target: decodes I/O cycles, drives sync and read data
   always_ff @(posedge sys_clk) begin
      regWr <= 1'b0;
      postKick <= 1'b0;
      if (!rst_n) begin
         state <= ST_IDLE;
         nib <= 2'h0;
         isWrite <= 1'b0;
         addr <= 16'h0000;
         wdata <= 8'h00;
         rdata <= 8'h00;
         regOff <= 3'h0;
         regData <= 8'h00;
         lpcAdOut <= LPC_TAR_DRIVE;
         lpcAdOe <= 1'b0;
      end else if (!lpcFrameN) begin
         // A frame start also aborts whatever was in progress
         lpcAdOe <= 1'b0;
         state <= (lpcAdIn == LPC_START) ? ST_CYCTYPE : ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               lpcAdOe <= 1'b0;
            end
            ST_CYCTYPE: begin
               nib <= 2'h0;
               isWrite <= (lpcAdIn[3:1] == LPC_IO_WRITE);
               if (lpcAdIn[3:1] == LPC_IO_WRITE ||
                   lpcAdIn[3:1] == LPC_IO_READ) begin
                  state <= ST_ADDR;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_ADDR: begin
               addr <= {addr[11:0], lpcAdIn};
               nib <= nib + 2'h1;
               if (nib == ADDR_NIBBLES_LAST) begin
                  nib <= 2'h0;
                  state <= isWrite ? ST_WDATA : ST_HOST_TAR;
               end
            end
            ST_WDATA: begin
               // Low nibble arrives first
               wdata <= {lpcAdIn, wdata[7:4]};
               nib <= nib + 2'h1;
               if (nib[0]) begin
                  nib <= 2'h0;
                  state <= ST_HOST_TAR;
               end
            end
            ST_HOST_TAR: begin
               nib <= nib + 2'h1;
               if (nib[0]) begin
                  nib <= 2'h0;
                  postKick <= isWrite && port80Enable && addr == POST_PORT;
                  if (hit) begin
                     state <= ST_SYNC;
                     lpcAdOut <= LPC_SYNC_READY;
                     lpcAdOe <= 1'b1;
                     regOff <= offset[2:0];
                     regData <= wdata;
                     regWr <= isWrite;
                     rdata <= readReg(offset[2:0]);
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_SYNC: begin
               if (isWrite) begin
                  state <= ST_DEV_TAR;
                  lpcAdOut <= LPC_TAR_DRIVE;
               end else begin
                  state <= ST_RDATA;
                  lpcAdOut <= rdata[3:0];
               end
            end
            ST_RDATA: begin
               nib <= nib + 2'h1;
               if (nib[0]) begin
                  nib <= 2'h0;
                  state <= ST_DEV_TAR;
                  lpcAdOut <= LPC_TAR_DRIVE;
               end else begin
                  lpcAdOut <= rdata[7:4];
               end
            end
            ST_DEV_TAR: begin
               // Drive ones for one cycle, then release the pins
               lpcAdOe <= 1'b0;
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // fractional divider keeps the long-term rate exact
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         phase <= 32'h00000000;
         tick <= 1'b0;
      end else if (phase + TICK_HZ >= 32'(CLK_HZ)) begin
         phase <= phase + TICK_HZ - 32'(CLK_HZ);
         tick <= 1'b1;
      end else begin
         phase <= phase + TICK_HZ;
         tick <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         count <= COUNT_RESET;
      end else if (countWrite || postKick) begin
         count <= reload;
      end else if (zeroEvent) begin
         count <= reload;
      end else if (tick && countEnable) begin
         count <= count - COUNT_LAST;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reload <= RELOAD_RESET;
      end else if (regWr && regOff == OFF_RELOAD_VALUE_BYTE0) begin
         reload[7:0] <= regData;
      end else if (regWr && regOff == OFF_RELOAD_VALUE_BYTE1) begin
         reload[15:8] <= regData;
      end else if (regWr && regOff == OFF_RELOAD_VALUE_BYTE2) begin
         reload[23:16] <= regData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         countEnable <= 1'b0;
         boardResetEnable <= 1'b0;
      end else if (regWr && regOff == OFF_WATCHDOG_CONTROL) begin
         countEnable <= regData[COUNT_ENABLE_BIT];
         boardResetEnable <= regData[BOARD_RESET_ENABLE_BIT];
      end
   end

   // Set wins over a clear landing in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         firstTimeoutFlag <= 1'b0;
      end else if (zeroEvent) begin
         firstTimeoutFlag <= 1'b1;
      end else if ((statusWrite && regData[FIRST_TIMEOUT_FLAG_BIT]) ||
                   postKick) begin
         firstTimeoutFlag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         secondTimeoutFlag <= 1'b0;
      end else if (zeroEvent && firstTimeoutFlag) begin
         secondTimeoutFlag <= 1'b1;
      end else if (statusWrite && regData[SECOND_TIMEOUT_FLAG_BIT]) begin
         secondTimeoutFlag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         watchdogIrq <= 1'b0;
         boardReset <= 1'b0;
      end else begin
         watchdogIrq <= firstTimeoutFlag || secondTimeoutFlag;
         boardReset <= secondTimeoutFlag && boardResetEnable;
      end
   end

endmodule // liw_watchdog

/* File: test/liw_host_model.sv */
// Host side of the bus: issues I/O cycles and resolves the shared nibble
`timescale 1ns/1ps
module liw_host_model (
   input wire logic sys_clk, // Clock
   output logic lpcFrameN, // Frame, active low
   output logic [3:0] lpcAdIn, // Resolved wire
   input wire logic [3:0] lpcAdOut, // Device value
   input wire logic lpcAdOe // Device enable
);
   logic [3:0] hostAd = 4'hf;
   logic hostOe = 1'b0;
   initial lpcFrameN = 1'b1;
   // Pulled up: a released wire reads all ones
   assign lpcAdIn = lpcAdOe ? lpcAdOut : (hostOe ? hostAd : 4'hf);
   task automatic put(input logic f, input logic [3:0] v, input logic e);
      @(posedge sys_clk);
      lpcFrameN <= f;
      hostAd <= v;
      hostOe <= e;
   endtask
   task automatic cyc(input logic wr, input logic [15:0] a,
         input logic [7:0] d, output logic [7:0] q, output logic ack);
      int i;
      q = 8'h00;
      ack = 1'b0;
      put(1'b0, 4'h0, 1'b1);
      put(1'b1, {2'h0, wr, 1'b0}, 1'b1);
      for (i = 3; i >= 0; i--) put(1'b1, a[4*i +: 4], 1'b1);
      if (wr) begin
         put(1'b1, d[3:0], 1'b1);
         put(1'b1, d[7:4], 1'b1);
      end
      put(1'b1, 4'hf, 1'b1);
      put(1'b1, 4'hf, 1'b0);
      for (i = 0; i < 8 && !ack; i++) begin
         @(posedge sys_clk);
         ack = lpcAdOe && lpcAdIn == 4'h0;
      end
      if (ack && !wr) begin
         @(posedge sys_clk);
         q[3:0] = lpcAdIn;
         @(posedge sys_clk);
         q[7:4] = lpcAdIn;
      end
      repeat (2) @(posedge sys_clk);
   endtask
endmodule // liw_host_model

/* File: test/liw_watchdog_props.sv */
// Port-level checks for the bus-attached watchdog
`timescale 1ns/1ps
module liw_watchdog_props
   import liw_pkg::*;
#(
   parameter int CLK_HZ = 200_000_000
) (
   input wire logic sys_clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic lpcFrameN, // Frame, active low
   input wire logic [3:0] lpcAdIn, // Wire value
   input wire logic [3:0] lpcAdOut, // Drive value
   input wire logic lpcAdOe, // Drive enable
   input wire logic [15:0] ioBase, // Register base
   input wire logic port80Enable, // Kick option
   input wire logic watchdogIrq, // Interrupt
   input wire logic boardReset // Board reset
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] sinceFrame;
   // Saturates so a long idle spell never wraps to a small value
   always_ff @(posedge sys_clk) begin
      if (!lpcFrameN) begin
         sinceFrame <= 8'h00;
      end else if (sinceFrame != 8'hff) begin
         sinceFrame <= sinceFrame + 8'h01;
      end
   end
   property p_quiet;
      $rose(rst_n) |-> !watchdogIrq && !boardReset && !lpcAdOe;
   endproperty
   a_quiet: assert property (p_quiet) else $error("active after reset");
   property p_sync;
      $rose(lpcAdOe) |-> lpcAdOut == LPC_SYNC_READY;
   endproperty
   a_sync: assert property (p_sync) else $error("answer not ready");
   property p_turn;
      $rose(lpcAdOe) |-> sinceFrame == 8'h07 || sinceFrame == 8'h09;
   endproperty
   a_turn: assert property (p_turn) else $error("answer misplaced");
   property p_end;
      $rose(lpcAdOe) |-> ##[1:3] lpcAdOut == 4'hf ##1 !lpcAdOe;
   endproperty
   a_end: assert property (p_end) else $error("release wrong");
   property p_abort;
      !lpcFrameN |=> !lpcAdOe;
   endproperty
   a_abort: assert property (p_abort) else $error("drive in frame");
   property p_rst_irq;
      boardReset |-> watchdogIrq;
   endproperty
   a_rst_irq: assert property (p_rst_irq) else $error("reset no irq");
   property p_second;
      $rose(boardReset) |-> $past(watchdogIrq);
   endproperty
   a_second: assert property (p_second) else $error("reset early");
   property p_clear;
      $fell(watchdogIrq) |-> sinceFrame < 8'h14;
   endproperty
   a_clear: assert property (p_clear) else $error("irq fell alone");
   c_read: cover property ($rose(lpcAdOe) && sinceFrame == 8'h07);
   c_first: cover property ($rose(watchdogIrq));
   c_brst: cover property ($rose(boardReset));
endmodule // liw_watchdog_props

bind liw_watchdog liw_watchdog_props #(.CLK_HZ(CLK_HZ))
   liw_watchdog_props_inst (
   .sys_clk(sys_clk), .rst_n(rst_n), .lpcFrameN(lpcFrameN),
   .lpcAdIn(lpcAdIn), .lpcAdOut(lpcAdOut), .lpcAdOe(lpcAdOe),
   .ioBase(ioBase), .port80Enable(port80Enable),
   .watchdogIrq(watchdogIrq), .boardReset(boardReset));

/* File: test/liw_watchdog_test.sv */
// Self-checking bench for the bus-attached watchdog
`timescale 1ns/1ps
module liw_watchdog_test;
   import liw_pkg::*;
   localparam logic [15:0] BASE = 16'h0300;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic port80Enable = 1'b0;
   logic [15:0] ioBase = BASE;
   logic lpcFrameN, lpcAdOe, watchdogIrq, boardReset;
   logic [3:0] lpcAdIn, lpcAdOut;
   int fails = 0;
   int total_checks = 0;
   initial forever #2.5 sys_clk = ~sys_clk;
   // Tick every two cycles keeps timeouts short
   liw_watchdog #(.CLK_HZ(65536)) liw_watchdog_inst (.sys_clk(sys_clk),
      .rst_n(rst_n), .lpcFrameN(lpcFrameN), .lpcAdIn(lpcAdIn),
      .lpcAdOut(lpcAdOut), .lpcAdOe(lpcAdOe), .ioBase(ioBase),
      .port80Enable(port80Enable), .watchdogIrq(watchdogIrq),
      .boardReset(boardReset));
   liw_host_model liw_host_model_inst (.sys_clk(sys_clk),
      .lpcFrameN(lpcFrameN), .lpcAdIn(lpcAdIn), .lpcAdOut(lpcAdOut),
      .lpcAdOe(lpcAdOe));
   task check(input string what, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task give_verdict;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [15:0] a,
         input logic [7:0] d, e, input logic ackExp);
      logic [7:0] q;
      logic ack;
      liw_host_model_inst.cyc(wr, a, d, q, ack);
      check("answer", {7'h00, ack}, {7'h00, ackExp});
      if (!wr && ackExp) check("read data", q, e);
   endtask
   task automatic wr(input logic [2:0] o, input logic [7:0] d);
      bus(1'b1, BASE + {13'h0000, o}, d, 8'h00, 1'b1);
   endtask
   task automatic rd(input logic [2:0] o, input logic [7:0] e);
      bus(1'b0, BASE + {13'h0000, o}, 8'h00, e, 1'b1);
   endtask
   task automatic wait_hi(input logic onReset, output int n);
      int i;
      for (i = 0; i < 400; i++) begin
         @(posedge sys_clk);
         if ((onReset ? boardReset : watchdogIrq) === 1'b1) break;
      end
      n = i;
      if (i == 400) begin
         fails++;
         give_verdict();
      end
   endtask
   task automatic t_regs;
      logic [7:0] pat [3] = '{8'ha5, 8'h5a, 8'hc3};
      int i;
      rd(OFF_WATCHDOG_CONTROL, 8'h00);
      check("irq", {7'h00, watchdogIrq}, 8'h00);
      for (i = 0; i < 3; i++) wr(3'(i + 3), pat[i]);
      for (i = 0; i < 3; i++) rd(3'(i + 3), pat[i]);
      wr(OFF_COUNT_NOW_BYTE1, 8'h00);
      for (i = 0; i < 3; i++) rd(3'(i), pat[i]);
      wr(OFF_WATCHDOG_CONTROL, 8'hfc);
      rd(OFF_WATCHDOG_CONTROL, 8'h00);
      wr(OFF_TIMEOUT_STATUS, 8'hff);
      rd(OFF_TIMEOUT_STATUS, 8'h00);
      bus(1'b0, BASE + REG_SPAN, 8'h00, 8'h00, 1'b0);
   endtask
   task t_timeout;
      int n;
      wr(OFF_RELOAD_VALUE_BYTE0, 8'h20);
      wr(OFF_RELOAD_VALUE_BYTE1, 8'h00);
      wr(OFF_RELOAD_VALUE_BYTE2, 8'h00);
      wr(OFF_COUNT_NOW_BYTE0, 8'h00);
      wr(OFF_WATCHDOG_CONTROL, 8'h03);
      // 32 ticks of two cycles each, plus the flag and irq stages
      wait_hi(1'b0, n);
      check("first interval", {7'h00, (n >= 60 && n <= 66)}, 8'h01);
      rd(OFF_TIMEOUT_STATUS, 8'h01);
      // Second interval runs on from the reload at the first zero
      wait_hi(1'b1, n);
      check("second interval", {7'h00, (n >= 47 && n <= 51)}, 8'h01);
      rd(OFF_TIMEOUT_STATUS, 8'h05);
      wr(OFF_WATCHDOG_CONTROL, 8'h02);
      @(posedge sys_clk);
      check("board reset", {7'h00, boardReset}, 8'h00);
      wr(OFF_WATCHDOG_CONTROL, 8'h00);
      wr(OFF_TIMEOUT_STATUS, 8'h01);
      rd(OFF_TIMEOUT_STATUS, 8'h04);
      wr(OFF_TIMEOUT_STATUS, 8'h04);
      rd(OFF_TIMEOUT_STATUS, 8'h00);
   endtask
   task t_post;
      int n;
      wr(OFF_COUNT_NOW_BYTE0, 8'h00);
      wr(OFF_WATCHDOG_CONTROL, 8'h02);
      wait_hi(1'b0, n);
      check("kick interval", {7'h00, (n >= 60 && n <= 66)}, 8'h01);
      bus(1'b1, POST_PORT, 8'h55, 8'h00, 1'b0);
      rd(OFF_TIMEOUT_STATUS, 8'h01);
      port80Enable <= 1'b1;
      bus(1'b1, POST_PORT, 8'h55, 8'h00, 1'b0);
      rd(OFF_TIMEOUT_STATUS, 8'h00);
      // Without the reload a new zero would land before this read
      rd(OFF_TIMEOUT_STATUS, 8'h00);
      wr(OFF_WATCHDOG_CONTROL, 8'h00);
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_regs;
      t_timeout;
      t_post;
      give_verdict();
   end
endmodule // liw_watchdog_test
